// *** common/sas_pkg.sv ***
package sas_pkg;

  // ---------------------------------------------------------------
  // register bus carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sas_bus_req_s;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SAS_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] SAS_OFS_CTRL2 = 8'h02;
  localparam logic [7:0] SAS_OFS_RESH = 8'h03;
  localparam logic [7:0] SAS_OFS_RESL = 8'h04;
  localparam logic [7:0] SAS_OFS_FLAG = 8'h05;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int SAS_BIT_ENABLE = 0;
  localparam int SAS_BIT_START = 1;
  localparam int SAS_BIT_DONE = 0;
  localparam int SAS_BIT_IRQ_EN = 1;
  localparam int SAS_POS_CLKSEL = 0;
  localparam int SAS_POS_ACQ = 3;
  localparam logic [2:0] SAS_RST_ACQ = 3'h0;
  localparam logic [2:0] SAS_RST_CLKSEL = 3'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SAS_CLK_MHZ = 200;
  localparam int SAS_TCY_NS = 20;
  localparam int SAS_TCY_CYC = (SAS_TCY_NS * SAS_CLK_MHZ + 999) / 1000;
  localparam int SAS_RC_TAD_NS = 1200;
  localparam int SAS_RC_DIV = (SAS_RC_TAD_NS * SAS_CLK_MHZ + 999) / 1000;
  localparam int SAS_CONV_TADS = 11;
  localparam int SAS_RES_BITS = 10;
  localparam int SAS_WAIT_TADS = 2;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SAS_ST_IDLE = 3'b000,
    SAS_ST_ACQ = 3'b001,
    SAS_ST_DELAY = 3'b010,
    SAS_ST_CONV = 3'b011,
    SAS_ST_WAIT = 3'b100
  } sas_state_e;

  // conversion clock divide decode
  function automatic logic [7:0] sas_div_f(input logic [2:0] sel);
    case (sel)
      3'h0: sas_div_f = 8'h02;
      3'h4: sas_div_f = 8'h04;
      3'h1: sas_div_f = 8'h08;
      3'h5: sas_div_f = 8'h10;
      3'h2: sas_div_f = 8'h20;
      3'h6: sas_div_f = 8'h40;
      default: sas_div_f = 8'(SAS_RC_DIV);
    endcase
  endfunction

  // acquisition length decode in conversion clock periods
  function automatic logic [4:0] sas_acq_f(input logic [2:0] sel);
    case (sel)
      3'h1: sas_acq_f = 5'h02;
      3'h2: sas_acq_f = 5'h04;
      3'h3: sas_acq_f = 5'h06;
      3'h4: sas_acq_f = 5'h08;
      3'h5: sas_acq_f = 5'h0C;
      3'h6: sas_acq_f = 5'h10;
      3'h7: sas_acq_f = 5'h14;
      default: sas_acq_f = 5'h00;
    endcase
  endfunction

endpackage

// *** rtl/sas_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module sas_tick_gen
  import sas_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] clk_sel,
  output logic tick
);

  logic [7:0] cnt_r;
  logic [7:0] div_w;

  assign div_w = sas_div_f(clk_sel);

  // divider, one pulse per conversion clock period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_r >= div_w - 8'h01) begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end

  AST_TICK_SPACING: assert property (@(posedge ref_clk) disable iff (rst)
    (tick && $stable(clk_sel) && div_w > 8'h01) |=> !tick)
    else $error("conversion clock tick repeated too soon");

endmodule
`default_nettype wire

// *** rtl/sas_adc_seq.sv ***
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - result pair not reset at power-on
// - nonzero acquisition field delays conversion start
// - zero field stops sampling immediately
// - completion clears start, sets flag, resamples
// - no phase status; start held throughout
// - conversion lasts eleven conversion clock periods
// - clock select decodes divider or RC
// - two periods wait before next acquisition
// - zero mode delays conversion one instruction
// - sampling switch opens when conversion starts
// - clearing start aborts, result kept
// - reset turns module off, aborts conversion
module sas_adc_seq
  import sas_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire sas_bus_req_s bus_req,
  output logic [7:0] rd_data,
  input wire logic cmp_in,
  output logic sample_en,
  output logic [9:0] dac_code,
  output logic conv_done_flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sas_state_e state_r;
  logic enable_r;
  logic start_r;
  logic irq_en_r;
  logic [2:0] acq_field_r;
  logic [2:0] clk_sel_r;
  logic [9:0] result_r;
  logic [9:0] trial_r;
  logic [9:0] trial_nxt;
  logic [4:0] cnt_r;
  logic [3:0] bit_cnt_r;
  logic tick;
  logic [4:0] acq_len;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_ctrl0;
  logic wr_ctrl2;
  logic wr_resh;
  logic wr_resl;
  logic wr_flag;
  logic conv_end;
  logic sw_stop;
  logic active;

  assign wr_ctrl0 = bus_req.wr && bus_req.addr == SAS_OFS_CTRL0;
  assign wr_ctrl2 = bus_req.wr && bus_req.addr == SAS_OFS_CTRL2;
  assign wr_resh = bus_req.wr && bus_req.addr == SAS_OFS_RESH;
  assign wr_resl = bus_req.wr && bus_req.addr == SAS_OFS_RESL;
  assign wr_flag = bus_req.wr && bus_req.addr == SAS_OFS_FLAG;
  assign acq_len = sas_acq_f(acq_field_r);
  // last period of the conversion
  assign conv_end = state_r == SAS_ST_CONV && tick && bit_cnt_r == 4'(SAS_RES_BITS);
  assign active = state_r == SAS_ST_ACQ || state_r == SAS_ST_DELAY || state_r == SAS_ST_CONV;
  // software dropping start or enable during a run
  assign sw_stop = active && wr_ctrl0 &&
    (!bus_req.wdata[SAS_BIT_START] || !bus_req.wdata[SAS_BIT_ENABLE]);

  // one successive approximation step
  function automatic logic [9:0] sar_step_f(input logic [9:0] code, input logic [3:0] idx,
                                            input logic keep);
    logic [9:0] mask;
    mask = 10'h200 >> idx;
    sar_step_f = (code & ~(keep ? 10'h000 : mask)) | (mask >> 1);
  endfunction

  assign trial_nxt = sar_step_f(trial_r, bit_cnt_r, cmp_in);

  // ---------------------------------------------------------------
  // conversion clock
  // ---------------------------------------------------------------
  sas_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_sel(clk_sel_r),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // enable and configuration fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_r <= 1'b0;
      acq_field_r <= SAS_RST_ACQ;
      clk_sel_r <= SAS_RST_CLKSEL;
      irq_en_r <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        enable_r <= bus_req.wdata[SAS_BIT_ENABLE];
      end
      if (wr_ctrl2) begin
        acq_field_r <= bus_req.wdata[SAS_POS_ACQ +: 3];
        clk_sel_r <= bus_req.wdata[SAS_POS_CLKSEL +: 3];
      end
      if (wr_flag) begin
        irq_en_r <= bus_req.wdata[SAS_BIT_IRQ_EN];
      end
    end
  end

  // start bit, held through acquisition and conversion
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      start_r <= 1'b0;
    end else if (conv_end) begin
      start_r <= 1'b0;
    end else if (wr_ctrl0) begin
      start_r <= bus_req.wdata[SAS_BIT_START] && bus_req.wdata[SAS_BIT_ENABLE] && enable_r;
    end else if (!enable_r) begin
      start_r <= 1'b0;
    end
  end

  // completion flag, hardware set wins over software clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_done_flag <= 1'b0;
    end else if (conv_end && !sw_stop) begin
      conv_done_flag <= 1'b1;
    end else if (wr_flag) begin
      conv_done_flag <= bus_req.wdata[SAS_BIT_DONE];
    end
  end

  // result pair, deliberately without reset
  always_ff @(posedge ref_clk) begin
    if (conv_end && !sw_stop) begin
      result_r <= trial_r;
    end else begin
      if (wr_resh) begin
        result_r[9:8] <= bus_req.wdata[1:0];
      end
      if (wr_resl) begin
        result_r[7:0] <= bus_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // sampling, acquisition, conversion and recovery wait
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= SAS_ST_IDLE;
      cnt_r <= 5'h00;
      bit_cnt_r <= 4'h0;
      trial_r <= 10'h000;
    end else if (!enable_r && state_r != SAS_ST_WAIT) begin
      state_r <= SAS_ST_IDLE;
      cnt_r <= 5'h00;
    end else if (sw_stop) begin
      state_r <= SAS_ST_WAIT;
      cnt_r <= 5'h00;
    end else begin
      case (state_r)
        SAS_ST_IDLE: begin
          cnt_r <= 5'h00;
          // park the trial code so the first compare sees midscale
          trial_r <= 10'h200;
          if (start_r) begin
            if (acq_len != 5'h00) begin
              state_r <= SAS_ST_ACQ;
            end else begin
              state_r <= SAS_ST_DELAY;
            end
          end
        end
        SAS_ST_ACQ: begin
          if (tick) begin
            if (cnt_r == acq_len - 5'h01) begin
              state_r <= SAS_ST_CONV;
              cnt_r <= 5'h00;
              bit_cnt_r <= 4'h0;
              trial_r <= 10'h200;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
        end
        SAS_ST_DELAY: begin
          if (cnt_r == 5'(SAS_TCY_CYC - 1)) begin
            state_r <= SAS_ST_CONV;
            cnt_r <= 5'h00;
            bit_cnt_r <= 4'h0;
            trial_r <= 10'h200;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        SAS_ST_CONV: begin
          if (tick) begin
            if (bit_cnt_r == 4'(SAS_RES_BITS)) begin
              state_r <= SAS_ST_WAIT;
              cnt_r <= 5'h00;
            end else begin
              trial_r <= trial_nxt;
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        SAS_ST_WAIT: begin
          if (tick) begin
            if (cnt_r == 5'(SAS_WAIT_TADS - 1)) begin
              state_r <= SAS_ST_IDLE;
              cnt_r <= 5'h00;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
        end
        default: begin
          state_r <= SAS_ST_IDLE;
          cnt_r <= 5'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // analog side outputs
  // ---------------------------------------------------------------
  // sampling switch closed only in sampling and acquisition
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sample_en <= 1'b0;
      dac_code <= 10'h000;
    end else begin
      sample_en <= enable_r && (state_r == SAS_ST_IDLE || (state_r == SAS_ST_ACQ && !sw_stop)) &&
                   !(state_r == SAS_ST_IDLE && start_r && acq_len == 5'h00);
      dac_code <= trial_r;
    end
  end

  // ---------------------------------------------------------------
  // read path, data in the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        SAS_OFS_CTRL0: rd_data <= {6'h00, start_r, enable_r};
        SAS_OFS_CTRL2: rd_data <= {2'h0, acq_field_r, clk_sel_r};
        SAS_OFS_RESH: rd_data <= {6'h00, result_r[9:8]};
        SAS_OFS_RESL: rd_data <= result_r[7:0];
        SAS_OFS_FLAG: rd_data <= {6'h00, irq_en_r, conv_done_flag};
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_go_zero;
    state_r == SAS_ST_IDLE && enable_r && start_r && acq_len == 5'h00 && !sw_stop;
  endsequence

  sequence s_go_acq;
    state_r == SAS_ST_IDLE && enable_r && start_r && acq_len != 5'h00 && !sw_stop;
  endsequence

  sequence s_conv_last;
    conv_end && enable_r && !sw_stop;
  endsequence

  AST_RESULT_KEPT: assert property (!conv_end && !wr_resh && !wr_resl |=> $stable(result_r))
    else $error("result changed without completion or write");

  AST_ACQ_ENTRY: assert property (s_go_acq |=> state_r == SAS_ST_ACQ && sample_en)
    else $error("programmed acquisition not entered");

  AST_ZERO_ACQ: assert property (s_go_zero |=> state_r == SAS_ST_DELAY ##1 !sample_en)
    else $error("zero acquisition did not stop sampling");

  AST_DONE: assert property (s_conv_last |=> !start_r && conv_done_flag && state_r == SAS_ST_WAIT)
    else $error("completion did not clear start and set flag");

  AST_START_HELD: assert property (active && !conv_end && !wr_ctrl0 && enable_r |=> start_r)
    else $error("start bit dropped during a run");

  AST_CONV_LEN: assert property (state_r == SAS_ST_CONV |-> bit_cnt_r <= 4'(SAS_RES_BITS))
    else $error("conversion ran past eleven periods");

  AST_WAIT_TWO: assert property (state_r == SAS_ST_WAIT && $past(state_r) != SAS_ST_WAIT
    |-> cnt_r == 5'h00 ##0 (state_r == SAS_ST_WAIT) [*2])
    else $error("recovery wait too short");

  AST_TCY_DELAY: assert property (s_go_zero ##1 (enable_r && !sw_stop) [*4] |=> state_r == SAS_ST_CONV)
    else $error("instruction cycle delay wrong");

  AST_HOLD_OPEN: assert property (state_r == SAS_ST_CONV |=> !sample_en)
    else $error("sampling switch closed during conversion");

  // recovery wait keeps the switch open, then sampling resumes
  AST_WAIT_OPEN: assert property (state_r == SAS_ST_WAIT |=> !sample_en)
    else $error("sampling resumed during recovery wait");

  AST_RESUME: assert property (state_r == SAS_ST_WAIT && tick && cnt_r == 5'(SAS_WAIT_TADS - 1) && enable_r
    && !start_r && !wr_ctrl0 |=> state_r == SAS_ST_IDLE ##1 sample_en)
    else $error("sampling not resumed after the wait");

  AST_FLAG_KEPT: assert property (sw_stop |=> $stable(conv_done_flag))
    else $error("aborted conversion touched the completion flag");

  AST_ABORT: assert property (sw_stop |=> state_r == SAS_ST_WAIT && $stable(result_r))
    else $error("abort did not stop the conversion");

  AST_MSB_FIRST: assert property (state_r == SAS_ST_CONV && tick && bit_cnt_r < 4'(SAS_RES_BITS)
    && enable_r && !sw_stop |=> trial_r[4'(9) - $past(bit_cnt_r)] == $past(cmp_in))
    else $error("approximation bit not resolved from comparator");

endmodule
`default_nettype wire

// *** tb/sas_ain_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// analog input, sample switch and comparator
// ---------------------------------------------------------------
module sas_ain_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [9:0] ain,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  output logic cmp_in
);
  logic [9:0] held_r;

  // holding node tracks input only while switch is closed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      held_r <= 10'h000;
    end else if (sample_en) begin
      held_r <= ain;
    end
  end

  // comparator against the trial code
  assign cmp_in = (held_r >= dac_code);
endmodule
`default_nettype wire

// *** tb/sar_adc_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_bench;
  import sas_pkg::*;
  localparam sas_bus_req_s IDLE = '{8'h00, 8'h00, 1'h0, 1'h0};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  sas_bus_req_s bus_req = IDLE;
  logic [7:0] rd_data;
  logic cmp_in;
  logic sample_en;
  logic [9:0] dac_code;
  logic conv_done_flag;
  logic [9:0] ain = 10'h2A5;
  logic [9:0] last_res;
  int fail_count = 0;
  int n_tests = 0;
  int acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int div_t[8] = '{2, 8, 32, SAS_RC_DIV, 4, 16, 64, SAS_RC_DIV};

  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  sas_adc_seq i_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .cmp_in(cmp_in), .sample_en(sample_en), .dac_code(dac_code), .conv_done_flag(conv_done_flag));
  sas_ain_model i_ain (.ref_clk(ref_clk), .rst(rst), .ain(ain), .sample_en(sample_en),
    .dac_code(dac_code), .cmp_in(cmp_in));

  // clock
  always #2.5 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    n_tests++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus_req <= '{a, d, 1'h1, 1'h0};
    @(posedge ref_clk) bus_req <= IDLE;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk) bus_req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge ref_clk) bus_req <= IDLE;
    #1;
    d = rd_data;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, output logic [7:0] d);
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // which 0 watches sample_en, 1 watches the done flag
  task automatic wait_sig(input int which, input logic lvl, output int n);
    n = 0;
    while (((which == 0) ? sample_en : conv_done_flag) !== lvl) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 6000) begin
        fail_count++;
        close_out();
      end
    end
  endtask

  task automatic chk_res(input logic [9:0] exp);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(SAS_OFS_RESH, hi);
    rd(SAS_OFS_RESL, lo);
    chk({hi, lo}, {6'h00, exp});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    rd_chk(SAS_OFS_CTRL0, 8'h00, d);
    rd_chk(SAS_OFS_CTRL2, 8'h00, d);
    wr(SAS_OFS_CTRL0, 8'h02);
    rd_chk(SAS_OFS_CTRL0, 8'h00, d);
    wr(SAS_OFS_CTRL2, 8'hFF);
    rd_chk(SAS_OFS_CTRL2, 8'h3F, d);
    wr(SAS_OFS_FLAG, 8'h01);
    rd_chk(SAS_OFS_FLAG, 8'h01, d);
    wr(SAS_OFS_FLAG, 8'h02);
    rd_chk(SAS_OFS_FLAG, 8'h02, d);
    wr(SAS_OFS_FLAG, 8'h00);
    wr(8'h01, 8'hFF);
    rd_chk(8'h01, 8'h00, d);
    rd_chk(SAS_OFS_FLAG, 8'h00, d);
  endtask

  task automatic t_zero();
    logic [7:0] d;
    int n;
    wr(SAS_OFS_CTRL2, 8'h00);
    wr(SAS_OFS_CTRL0, 8'h01);
    repeat (20) @(posedge ref_clk);
    wr(SAS_OFS_CTRL0, 8'h03);
    wait_sig(0, 1'h0, n);
    chk_rng(n, 1, 4);
    ain <= 10'h15A;
    rd_chk(SAS_OFS_CTRL0, 8'h03, d);
    wait_sig(1, 1'h1, n);
    chk_rng(n, SAS_TCY_CYC + 14, SAS_TCY_CYC + 26);
    rd_chk(SAS_OFS_CTRL0, 8'h01, d);
    rd_chk(SAS_OFS_FLAG, 8'h01, d);
    chk_res(10'h2A5);
    wait_sig(0, 1'h1, n);
    chk({15'h0000, sample_en}, 16'h0001);
    wr(SAS_OFS_FLAG, 8'h00);
    rd_chk(SAS_OFS_FLAG, 8'h00, d);
  endtask

  task automatic t_acq();
    int n;
    for (int k = 1; k < 8; k++) begin
      wr(SAS_OFS_CTRL2, 8'(k << 3));
      wr(SAS_OFS_CTRL0, 8'h03);
      wait_sig(0, 1'h0, n);
      chk_rng(n, 2 * acq_t[k] - 2, 2 * acq_t[k] + 4);
      wait_sig(1, 1'h1, n);
      wr(SAS_OFS_FLAG, 8'h00);
      wait_sig(0, 1'h1, n);
    end
  endtask

  task automatic t_clk();
    int n;
    for (int s = 0; s < 8; s++) begin
      wr(SAS_OFS_CTRL2, 8'h08 | 8'(s));
      wr(SAS_OFS_CTRL0, 8'h03);
      wait_sig(0, 1'h0, n);
      wait_sig(1, 1'h1, n);
      chk_rng(n, 10 * div_t[s], 11 * div_t[s] + 6);
      wait_sig(0, 1'h1, n);
      chk_rng(n, div_t[s], 2 * div_t[s] + 4);
      chk_res(10'h15A);
      wr(SAS_OFS_FLAG, 8'h00);
    end
    last_res = 10'h15A;
  endtask

  task automatic t_abort();
    logic [7:0] d;
    int n;
    ain <= 10'h0F0;
    wr(SAS_OFS_CTRL2, 8'h06);
    wr(SAS_OFS_CTRL0, 8'h03);
    wait_sig(0, 1'h0, n);
    repeat (200) @(posedge ref_clk);
    wr(SAS_OFS_CTRL0, 8'h01);
    repeat (800) @(posedge ref_clk);
    rd_chk(SAS_OFS_FLAG, 8'h00, d);
    chk_res(last_res);
    wait_sig(0, 1'h1, n);
  endtask

  task automatic t_rst();
    logic [7:0] d;
    int n;
    wr(SAS_OFS_CTRL0, 8'h03);
    wait_sig(0, 1'h0, n);
    repeat (100) @(posedge ref_clk);
    rst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({15'h0000, sample_en}, 16'h0000);
    @(posedge ref_clk) rst <= 1'h0;
    rd_chk(SAS_OFS_CTRL0, 8'h00, d);
    rd_chk(SAS_OFS_CTRL2, 8'h00, d);
    chk_res(last_res);
    wr(SAS_OFS_RESH, 8'hFD);
    wr(SAS_OFS_RESL, 8'h23);
    chk_res(10'h123);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    t_regs();
    t_zero();
    t_acq();
    t_clk();
    t_abort();
    t_rst();
    close_out();
  end
endmodule
`default_nettype wire
